/* pin_emitter_regs.vh */
// register offsets, field positions and reset values for the
// pin routing and emitter drive configuration block.
// assumes an 8-bit register address and 24-bit register data.
`ifndef PIN_EMITTER_REGS_VH
`define PIN_EMITTER_REGS_VH

`define ADDR_WIDTH 8
`define DATA_WIDTH 24

// register offsets
`define GENERAL_PIN_ROUTING_CONFIG_ADDR 8'h78
`define EMITTER_DRIVE_CONFIG_ADDR 8'h79

// reset values
`define GENERAL_PIN_ROUTING_CONFIG_RESET 24'h000000
`define EMITTER_DRIVE_CONFIG_RESET 24'h000001

// general_pin_routing_config fields
`define RELOCATE_PIN3_BIT 22
`define PIN2_IBUF_BIT 16
`define PIN2_OBUF_BIT 15
`define PIN1_OBUF_BIT 12
`define PIN2_SEL_HI 11
`define PIN2_SEL_LO 9
`define PIN1_SEL_HI 8
`define PIN1_SEL_LO 6
`define PIN3_SEL_HI 2
`define PIN3_SEL_LO 0

// emitter_drive_config fields
`define DRIVER_PDN_BIT 19
`define BIAS_PDN_BIT 12
`define BIAS_CODE_HI 11
`define BIAS_CODE_LO 8
`define ALL_BIAS_BIT 4
`define SHARE_CH01_BIT 3
`define INV_CLK_EN_BIT 2
`define TRUE_CLK_EN_BIT 0

// output selector codes
`define SEL_GROUND 3'h0
`define SEL_DIG_ZERO 3'h2
`define SEL_DIG_ONE 3'h3
`define SEL_SPECIAL 3'h7

// bias current per code step, in microamps
`define BIAS_STEP_UA 500

`endif

/* pin_emitter_config.v */
// pin routing and emitter drive configuration: two registers that steer
// three general pins, the auxiliary data pin and the emitter driver.
// assumes register port and all sources synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "pin_emitter_regs.vh"

// Function
// [RULE_01] relocation bit drives pin three's source onto aux data pin, active low.
// [RULE_02] pin two input buffer enabled only while its enable bit is one.
// [RULE_03] pin two output driver follows its output-buffer enable bit.
// [RULE_04] pin one output driver follows its output-buffer enable bit.
// [RULE_05] pin two selector: 0 ground, 2 out zero, 3 out one, 7 channel-zero enable.
// [RULE_06] pin one selector: 0 ground, 2 out zero, 3 out one, 7 modulation clock.
// [RULE_07] pin three selector: 0 ground, 2 out zero, 3 out one, 7 out two.
// [RULE_08] software writes zero to reserved fields and reads zero back.
// [RULE_09] driver power-down bit set powers down the illumination driver.
// [RULE_10] bias power-down bit set switches off transmit pin bias current.
// [RULE_11] bias current equals four-bit code times half a milliampere.
// [RULE_12] all-channel bias bit with channel zero selected biases every channel.
// [RULE_13] sharing bit drives channel one from channel-zero enable, else channel select.
// [RULE_14] inverted modulation clock passes only while its enable is one; resets off.
// [RULE_15] true modulation clock passes while its enable is one; resets on.
// [RULE_16] invalid selector codes drive the pin source low like ground.
module pin_emitter_config (
    input wire clk,
    input wire rst,
    input wire [`ADDR_WIDTH-1:0] reg_addr,
    input wire reg_write,
    input wire [`DATA_WIDTH-1:0] reg_write_data,
    input wire reg_read,
    output reg [`DATA_WIDTH-1:0] reg_read_data,
    input wire digital_output_zero,
    input wire digital_output_one,
    input wire digital_output_two,
    input wire channel_zero_illumination_enable,
    input wire illumination_modulation_clock,
    input wire [1:0] transmit_channel_select,
    output reg general_pin_one_out,
    output reg general_pin_one_oe,
    output reg general_pin_two_out,
    output reg general_pin_two_oe,
    input wire general_pin_two_in,
    output reg reference_clock_in,
    output reg general_pin_three_out,
    output reg general_pin_three_oe,
    output reg aux_data_out,
    output reg aux_data_oe,
    output reg driver_test_power_down,
    output reg bias_current_power_down,
    output reg [3:0] bias_current_code,
    output reg all_channel_bias_active,
    output reg transmit_channel_one_enable,
    output reg inverted_mod_clock,
    output reg true_mod_clock
);

    reg [`DATA_WIDTH-1:0] general_pin_routing_config;
    reg [`DATA_WIDTH-1:0] emitter_drive_config;
    reg [`DATA_WIDTH-1:0] next_read_data;
    wire [`DATA_WIDTH-1:0] routing_mask;
    wire [`DATA_WIDTH-1:0] emitter_mask;
    wire pin1_source;
    wire pin2_source;
    wire pin3_source;
    wire relocate;

    // only defined fields are stored, so reserved bits always read zero
    assign routing_mask = (24'h000001 << `RELOCATE_PIN3_BIT) | (24'h000001 << `PIN2_IBUF_BIT)
        | (24'h000001 << `PIN2_OBUF_BIT) | (24'h000001 << `PIN1_OBUF_BIT)
        | 24'h000fc7;
    assign emitter_mask = (24'h000001 << `DRIVER_PDN_BIT) | (24'h000001 << `BIAS_PDN_BIT)
        | 24'h000f1d;

    // shared selector decode; unlisted codes fall back to ground [RULE_16]
    function route_pin;
        input [2:0] sel;
        input zero_src;
        input one_src;
        input special_src;
        begin
            case (sel)
                `SEL_GROUND: route_pin = 1'b0;
                `SEL_DIG_ZERO: route_pin = zero_src;
                `SEL_DIG_ONE: route_pin = one_src;
                `SEL_SPECIAL: route_pin = special_src;
                default: route_pin = 1'b0;
            endcase
        end
    endfunction

    // per-pin source selection [RULE_05] [RULE_06] [RULE_07]
    assign pin1_source = route_pin(general_pin_routing_config[`PIN1_SEL_HI:`PIN1_SEL_LO],
        digital_output_zero, digital_output_one, illumination_modulation_clock);
    assign pin2_source = route_pin(general_pin_routing_config[`PIN2_SEL_HI:`PIN2_SEL_LO],
        digital_output_zero, digital_output_one, channel_zero_illumination_enable);
    assign pin3_source = route_pin(general_pin_routing_config[`PIN3_SEL_HI:`PIN3_SEL_LO],
        digital_output_zero, digital_output_one, digital_output_two);
    assign relocate = general_pin_routing_config[`RELOCATE_PIN3_BIT];

    // register writes; reserved bits are dropped [RULE_08]
    always @(posedge clk) begin
        if (rst) begin
            general_pin_routing_config <= `GENERAL_PIN_ROUTING_CONFIG_RESET;
            emitter_drive_config <= `EMITTER_DRIVE_CONFIG_RESET; // [RULE_14] [RULE_15]
        end else if (reg_write) begin
            if (reg_addr == `GENERAL_PIN_ROUTING_CONFIG_ADDR) begin
                general_pin_routing_config <= reg_write_data & routing_mask;
            end
            if (reg_addr == `EMITTER_DRIVE_CONFIG_ADDR) begin
                emitter_drive_config <= reg_write_data & emitter_mask;
            end
        end
    end

    // read decode; unmapped addresses answer zero
    always @* begin
        next_read_data = {`DATA_WIDTH{1'b0}};
        if (reg_addr == `GENERAL_PIN_ROUTING_CONFIG_ADDR) begin
            next_read_data = general_pin_routing_config;
        end else if (reg_addr == `EMITTER_DRIVE_CONFIG_ADDR) begin
            next_read_data = emitter_drive_config;
        end
    end

    // read data holds until the next read strobe
    always @(posedge clk) begin
        if (rst) begin
            reg_read_data <= {`DATA_WIDTH{1'b0}};
        end else if (reg_read) begin
            reg_read_data <= next_read_data;
        end
    end

    // pin drivers, registered so every output comes from a flip-flop
    always @(posedge clk) begin
        if (rst) begin
            general_pin_one_out <= 1'b0;
            general_pin_one_oe <= 1'b0;
            general_pin_two_out <= 1'b0;
            general_pin_two_oe <= 1'b0;
            reference_clock_in <= 1'b0;
            general_pin_three_out <= 1'b0;
            general_pin_three_oe <= 1'b0;
            aux_data_out <= 1'b0;
            aux_data_oe <= 1'b0;
        end else begin
            general_pin_one_out <= pin1_source;
            general_pin_one_oe <= general_pin_routing_config[`PIN1_OBUF_BIT]; // [RULE_04]
            general_pin_two_out <= pin2_source;
            general_pin_two_oe <= general_pin_routing_config[`PIN2_OBUF_BIT]; // [RULE_03]
            // gated input keeps a floating pin off the reference clock
            reference_clock_in <= general_pin_two_in
                & general_pin_routing_config[`PIN2_IBUF_BIT]; // [RULE_02]
            general_pin_three_out <= pin3_source;
            general_pin_three_oe <= ~relocate;
            // open drain: pull low when the function is high, pull-up gives idle high
            aux_data_out <= 1'b0;
            aux_data_oe <= relocate & pin3_source; // [RULE_01]
        end
    end

    // emitter drive controls
    always @(posedge clk) begin
        if (rst) begin
            driver_test_power_down <= 1'b0;
            bias_current_power_down <= 1'b0;
            bias_current_code <= 4'h0;
            all_channel_bias_active <= 1'b0;
            transmit_channel_one_enable <= 1'b0;
            inverted_mod_clock <= 1'b0;
            true_mod_clock <= 1'b0;
        end else begin
            driver_test_power_down <= emitter_drive_config[`DRIVER_PDN_BIT]; // [RULE_09]
            bias_current_power_down <= emitter_drive_config[`BIAS_PDN_BIT]; // [RULE_10]
            // analog side scales this code by the step current
            bias_current_code <= emitter_drive_config[`BIAS_CODE_HI:`BIAS_CODE_LO]; // [RULE_11]
            all_channel_bias_active <= emitter_drive_config[`ALL_BIAS_BIT]
                & (transmit_channel_select == 2'h0); // [RULE_12]
            if (emitter_drive_config[`SHARE_CH01_BIT]) begin
                transmit_channel_one_enable <= channel_zero_illumination_enable; // [RULE_13]
            end else begin
                transmit_channel_one_enable <= (transmit_channel_select == 2'h1); // [RULE_13]
            end
            // clocks pass one cycle late; fine as long as the source is slower than clk/2
            inverted_mod_clock <= ~illumination_modulation_clock
                & emitter_drive_config[`INV_CLK_EN_BIT]; // [RULE_14]
            true_mod_clock <= illumination_modulation_clock
                & emitter_drive_config[`TRUE_CLK_EN_BIT]; // [RULE_15]
        end
    end

endmodule
`default_nettype wire

/* pin_emitter_config_assertions.sv */
// checker for the pin routing and emitter drive block, bound into it
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pin_emitter_config_check (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [23:0] reg_write_data,
    input wire logic illumination_modulation_clock,
    input wire logic general_pin_two_in,
    input wire logic general_pin_one_out,
    input wire logic general_pin_one_oe,
    input wire logic reference_clock_in,
    input wire logic driver_test_power_down,
    input wire logic [3:0] bias_current_code,
    input wire logic inverted_mod_clock,
    input wire logic true_mod_clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // writes reach the outputs two edges later
    sequence wr78;
        reg_write && reg_addr == 8'h78;
    endsequence
    sequence wr79;
        reg_write && reg_addr == 8'h79;
    endsequence
    chk_true_clock_gate: assert property (true_mod_clock |-> $past(illumination_modulation_clock))
        else $error("true clock high without source");
    chk_inv_clock_gate: assert property (inverted_mod_clock |-> !$past(illumination_modulation_clock))
        else $error("inverted clock follows wrong phase");
    chk_clock_disable: assert property (wr79 ##0 !reg_write_data[0] |-> ##2 !true_mod_clock)
        else $error("true clock runs while disabled");
    chk_driver_pdn: assert property (wr79 |-> ##2 driver_test_power_down == $past(reg_write_data[19], 2))
        else $error("driver power-down mismatch");
    chk_bias_code: assert property (wr79 |-> ##2 bias_current_code == $past(reg_write_data[11:8], 2))
        else $error("bias code mismatch");
    chk_pin1_drive: assert property (wr78 |-> ##2 general_pin_one_oe == $past(reg_write_data[12], 2))
        else $error("pin one drive enable mismatch");
    chk_bad_sel_low: assert property (wr78 ##0 reg_write_data[8:6] inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6}
        |-> ##2 !general_pin_one_out)
        else $error("pin one not low for ground or bad code");
    chk_refclk_gate: assert property (reference_clock_in |-> $past(general_pin_two_in))
        else $error("reference clock without pin level");
endmodule
bind pin_emitter_config pin_emitter_config_check chk (.*);
`default_nettype wire

/* pin_far_side.sv */
// far side of the pins: outside source on pin two, pull-up on aux data
// assumes the block's split out/enable pin ports
`timescale 1ns/1ps
`default_nettype none
module pin_far_side (
    input wire logic general_pin_two_out,
    input wire logic general_pin_two_oe,
    input wire logic far_drive,
    input wire logic aux_data_out,
    input wire logic aux_data_oe,
    output logic general_pin_two_in,
    output logic aux_data_level
);
    // block wins the pin two wire while it drives
    assign general_pin_two_in = general_pin_two_oe ? general_pin_two_out : far_drive;
    // aux line rests high on its pull-up, only pulled down
    assign aux_data_level = aux_data_oe ? aux_data_out : 1'b1;
endmodule
`default_nettype wire

/* pin_and_emitter_output_config_test.sv */
// self-checking bench for the pin routing and emitter drive block
// assumes the far-side pin model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module pin_and_emitter_output_config_test;
    logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, far_drive = 0, obs = 0, obs_rd = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_write_data = 24'h000000, reg_read_data, r78, r79, pins;
    logic digital_output_zero = 0, digital_output_one = 0, digital_output_two = 0;
    logic channel_zero_illumination_enable = 0, illumination_modulation_clock = 0;
    logic [1:0] transmit_channel_select = 2'h0;
    logic general_pin_one_out, general_pin_one_oe, general_pin_two_out, general_pin_two_oe;
    logic general_pin_two_in, reference_clock_in, general_pin_three_out, general_pin_three_oe;
    logic aux_data_out, aux_data_oe, aux_data_level, driver_test_power_down;
    logic bias_current_power_down, all_channel_bias_active, transmit_channel_one_enable;
    logic inverted_mod_clock, true_mod_clock;
    logic [3:0] bias_current_code;
    logic [23:0] exp_q[$];
    int num_errors = 0, n_compared = 0, cyc = 0;
    always #12.5 clk = ~clk;
    pin_emitter_config uut (.*);
    pin_far_side far (.*);
    assign pins = {6'h00, general_pin_one_out, general_pin_one_oe, general_pin_two_out,
        general_pin_two_oe, reference_clock_in, general_pin_three_out, general_pin_three_oe,
        aux_data_level, driver_test_power_down, bias_current_power_down, bias_current_code,
        all_channel_bias_active, transmit_channel_one_enable, inverted_mod_clock, true_mod_clock};
    function automatic logic src(input logic [2:0] s, input logic c);
        return s == 3'h2 ? digital_output_zero : s == 3'h3 ? digital_output_one : s == 3'h7 & c;
    endfunction
    // expected pin and emitter levels from the two register images
    function automatic logic [23:0] expect_pins();
        logic p2, p3;
        p2 = src(r78[11:9], channel_zero_illumination_enable);
        p3 = src(r78[2:0], digital_output_two);
        return {6'h00, src(r78[8:6], illumination_modulation_clock), r78[12], p2, r78[15],
            r78[16] & (r78[15] ? p2 : far_drive), p3, ~r78[22], ~(r78[22] & p3),
            r79[19], r79[12], r79[11:8], r79[4] & transmit_channel_select == 2'h0,
            r79[3] ? channel_zero_illumination_enable : transmit_channel_select == 2'h1,
            ~illumination_modulation_clock & r79[2], illumination_modulation_clock & r79[0]};
    endfunction
    task automatic complete_run();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic compare(input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic access(input logic [7:0] a, input logic [23:0] d, input logic w, input logic r);
        reg_addr <= a;
        reg_write_data <= d;
        reg_write <= w;
        reg_read <= r;
        @(posedge clk);
    endtask
    // note the expectation; the monitor compares one edge later
    task automatic note(input logic [23:0] e, input logic is_rd);
        exp_q.push_back(e);
        obs <= 1'b1;
        obs_rd <= is_rd;
        reg_read <= 1'b0;
        @(posedge clk);
        obs <= 1'b0;
        // one quiet edge so a following note never re-drives obs in this step
        @(posedge clk);
    endtask
    // monitor, also the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
        if (obs) compare(exp_q.pop_front(), obs_rd ? reg_read_data : pins);
    end
    initial begin
        void'($urandom(32'hbdac));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        r78 = 24'h000000;
        r79 = 24'h000001;
        access(8'h78, 24'h000000, 0, 1);
        note(r78, 1);
        access(8'h79, 24'h000000, 0, 1);
        note(r79, 1);
        note(expect_pins(), 0);
        // walk every selector code, random fields and sources
        for (int i = 0; i < 40; i++) begin
            r78 = $urandom & 24'h419fc7;
            r78[8:6] = i[2:0];
            r78[11:9] = i[2:0] + 3'h3;
            r78[2:0] = i[2:0] + 3'h5;
            r79 = $urandom & 24'h081f1d;
            access(8'h78, r78, 1, 0);
            access(8'h79, r79, 1, 0);
            {digital_output_zero, digital_output_one, digital_output_two, far_drive,
                channel_zero_illumination_enable, illumination_modulation_clock,
                transmit_channel_select} <= 8'($urandom);
            access(8'h00, 24'h000000, 0, 0);
            repeat (2) @(posedge clk);
            note(expect_pins(), 0);
            access(8'h78, 24'h000000, 0, 1);
            note(r78, 1);
            access(8'h79, 24'h000000, 0, 1);
            note(r79, 1);
        end
        // reserved bits dropped, unmapped place reads zero
        access(8'h78, 24'hffffff, 1, 0);
        access(8'h7a, 24'hffffff, 1, 0);
        access(8'h78, 24'h000000, 0, 1);
        note(24'h419fc7, 1);
        access(8'h7a, 24'h000000, 0, 1);
        note(24'h000000, 1);
        complete_run();
    end
endmodule
`default_nettype wire
